// ---- shared/cscr_pkg.sv ----
// Shared constants and types for the charger status and current registers.
package cscr_pkg;
   // Command codes of the three registers on the management bus.
   localparam logic [7:0] CMD_CHG_CUR = 8'h14;
   localparam logic [7:0] CMD_STATUS = 8'h20;
   localparam logic [7:0] CMD_PROCESSOR_HOT_SIGNAL = 8'h21;
   // Field layout of the charge current setting and the status words.
   localparam int CC_LSB = 6;
   localparam int CC_W = 7;
   localparam int CC_RSV_LSB = 13;
   localparam int WORD_W = 16;
   localparam int ST_SOVP_BIT = 4;
   localparam int FLT_N = 6;
   localparam int TRG_N = 7;
   // Values after reset.
   localparam logic [CC_W-1:0] CC_RST = 7'h00;
   localparam logic [FLT_N-1:0] FLT_RST = 6'h00;
   localparam logic [TRG_N-1:0] TRG_RST = 7'h00;
   localparam logic SOVP_RST = 1'b0;
   localparam logic CONV_EN_RST = 1'b1;
   // Bus byte and bit counts.
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   // Positions of the pin inputs within the synchroniser vector.
   localparam int IX_ADP = 0;
   localparam int IX_ICO = 1;
   localparam int IX_VIN = 2;
   localparam int IX_IIN = 3;
   localparam int IX_FCH = 4;
   localparam int IX_PCH = 5;
   localparam int IX_OTG = 6;
   localparam int IX_FLT = 7;
   localparam int IX_ACOV = 12;
   localparam int IX_SOVP = 13;
   localparam int IX_BATP = 14;
   localparam int IX_SCL = 15;
   localparam int IX_SDA = 16;
   localparam int IX_TRG = 17;
   localparam int SYNC_W = 24;
   // The idle bus lines rest high, every other pin rests low.
   localparam logic [SYNC_W-1:0] SYNC_RST = 24'h018000;
   typedef enum logic [2:0] {
      S_IDLE, S_RX, S_ACKO, S_TX, S_ACKI, S_SKIP
   } cscr_state_t;
endpackage

// ---- shared/cscr_sync_if.sv ----
// Raw and cleaned pin levels passed between the top and its synchroniser.
`timescale 1ns/1ps
interface cscr_sync_if #(
   parameter int W = 1
);
   logic [W-1:0] raw;
   logic [W-1:0] clean;
   modport syncer (input raw, output clean);
   modport user (output raw, input clean);
endinterface

// ---- rtl/cscr_pin_sync.sv ----
// Three-stage synchroniser bank with agreement filter for pin inputs.
`timescale 1ns/1ps
module cscr_pin_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST = '0
) (
   input wire logic clk_sys,
   input wire logic rstn,
   cscr_sync_if.syncer sp
);
   logic [W-1:0] ff1_r;
   logic [W-1:0] ff2_r;
   logic [W-1:0] ff3_r;
   logic [W-1:0] clean_r;

   // A level is accepted only when stages two and three agree.
   genvar g;
   generate
      for (g = 0; g < W; g = g + 1) begin : g_bit
         always_ff @(posedge clk_sys or negedge rstn) begin
            if (!rstn) begin
               ff1_r[g] <= RST[g];
               ff2_r[g] <= RST[g];
               ff3_r[g] <= RST[g];
               clean_r[g] <= RST[g];
            end else begin
               ff1_r[g] <= sp.raw[g];
               ff2_r[g] <= ff1_r[g];
               ff3_r[g] <= ff2_r[g];
               if (ff2_r[g] == ff3_r[g]) begin
                  clean_r[g] <= ff3_r[g];
               end
            end
         end
      end
   endgenerate

   assign sp.clean = clean_r;
endmodule // cscr_pin_sync

// ---- rtl/cscr_regs.sv ----
// Charger status, trigger status and charge current registers on SMBus.
`timescale 1ns/1ps
module cscr_regs #(
   parameter logic [6:0] DEV_ADDR = 7'h5A // Arbitrary bus address.
) (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic smbus_scl,
   input wire logic smbus_sda_i,
   output logic smbus_sda_o,
   output logic smbus_sda_oe,
   input wire logic adapter_good_pin,
   input wire logic current_optimizer_done,
   input wire logic input_voltage_regulating,
   input wire logic input_current_regulating,
   input wire logic fast_charge_active,
   input wire logic precharge_active,
   input wire logic reverse_boost_active,
   input wire logic input_overvoltage_fault,
   input wire logic battery_overcurrent_fault,
   input wire logic input_overcurrent_fault,
   input wire logic latchoff_fault,
   input wire logic reverse_overvoltage_fault,
   input wire logic reverse_overcurrent_fault,
   input wire logic system_overvoltage_detect,
   input wire logic cell_count_battery_present_pin,
   input wire logic [cscr_pkg::TRG_N-1:0] processor_hot_trigger,
   output logic converter_enable,
   output logic [cscr_pkg::CC_W-1:0] charge_current_code
);
   import cscr_pkg::*;

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rstn);

   cscr_sync_if #(.W(SYNC_W)) sif ();
   logic [SYNC_W-1:0] pin;
   logic scl_q_r;
   logic sda_q_r;
   logic adp_q_r;
   logic batp_q_r;
   cscr_state_t st_r;
   cscr_state_t nxt_st_r;
   logic [3:0] bit_cnt_r;
   logic [1:0] idx_r;
   logic [7:0] shift_r;
   logic [7:0] cmd_r;
   logic [7:0] wlo_r;
   logic [7:0] tx_sh_r;
   logic [7:0] tx_hi_r;
   logic hi_sent_r;
   logic sda_low_r;
   logic [WORD_W-1:0] rd_snap_r;
   logic [WORD_W-1:0] wr_data_r;
   logic wr_stb_r;
   logic rd_done_r;
   logic [FLT_N-1:0] flt_r;
   logic [FLT_N-1:0] flt_nxt;
   logic [TRG_N-1:0] trg_r;
   logic [TRG_N-1:0] trg_nxt;
   logic sovp_r;
   logic sovp_nxt;
   logic conv_en_r;
   logic [CC_W-1:0] cc_r;
   logic [CC_W-1:0] cc_nxt;

   assign sif.raw = {processor_hot_trigger, smbus_sda_i, smbus_scl,
      cell_count_battery_present_pin, system_overvoltage_detect,
      input_overvoltage_fault, battery_overcurrent_fault,
      input_overcurrent_fault, latchoff_fault, reverse_overvoltage_fault,
      reverse_overcurrent_fault, reverse_boost_active, precharge_active,
      fast_charge_active, input_current_regulating,
      input_voltage_regulating, current_optimizer_done, adapter_good_pin};

   cscr_pin_sync #(.W(SYNC_W), .RST(SYNC_RST)) u_sync (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .sp(sif.syncer)
   );

   assign pin = sif.clean;

   // Bus conditions seen on the filtered lines.
   wire scl_rise = pin[IX_SCL] & ~scl_q_r;
   wire scl_fall = ~pin[IX_SCL] & scl_q_r;
   wire start_det = pin[IX_SCL] & scl_q_r & sda_q_r & ~pin[IX_SDA];
   wire stop_det = pin[IX_SCL] & scl_q_r & ~sda_q_r & pin[IX_SDA];
   wire adp_fall = adp_q_r & ~pin[IX_ADP];
   wire batp_fall = batp_q_r & ~pin[IX_BATP];
   wire byte_done = scl_fall && (bit_cnt_r == BITS_PER_BYTE);
   wire addr_hit = (idx_r == 2'd0) && (shift_r[7:1] == DEV_ADDR);
   wire rx_ack = (idx_r != 2'd0) || addr_hit;
   wire is_read = (idx_r == 2'd0) && shift_r[0];

   // Register words as the host reads them.
   wire [WORD_W-1:0] st_word = {pin[IX_ADP],
      pin[IX_ICO], 1'b0,
      pin[IX_VIN],
      pin[IX_IIN],
      pin[IX_FCH], pin[IX_PCH],
      pin[IX_OTG],
      flt_r[5:3], sovp_r, 1'b0, flt_r[2:0]};
   wire [WORD_W-1:0] trg_word = {{(WORD_W-TRG_N){1'b0}}, trg_r};
   wire [WORD_W-1:0] cc_word = {{(WORD_W-CC_LSB-CC_W){1'b0}}, cc_r,
      {CC_LSB{1'b0}}};
   wire [WORD_W-1:0] rd_word = (cmd_r == CMD_CHG_CUR) ? cc_word :
      (cmd_r == CMD_STATUS) ? st_word :
      (cmd_r == CMD_PROCESSOR_HOT_SIGNAL) ? trg_word : 16'h0000;

   // Edge history for the bus and the pins that cause clears.
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         scl_q_r <= 1'b1;
         sda_q_r <= 1'b1;
         adp_q_r <= 1'b0;
         batp_q_r <= 1'b0;
      end else begin
         scl_q_r <= pin[IX_SCL];
         sda_q_r <= pin[IX_SDA];
         adp_q_r <= pin[IX_ADP];
         batp_q_r <= pin[IX_BATP];
      end
   end

   // Bus slave: address, command, then a word low byte first.
   // Without clock stretching the host must leave a few system clocks
   // between an SCL fall and its next data sample.
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         st_r <= S_IDLE;
         nxt_st_r <= S_IDLE;
         bit_cnt_r <= 4'h0;
         idx_r <= 2'd0;
         shift_r <= 8'h00;
         cmd_r <= 8'h00;
         wlo_r <= 8'h00;
         tx_sh_r <= 8'h00;
         tx_hi_r <= 8'h00;
         hi_sent_r <= 1'b0;
         sda_low_r <= 1'b0;
         rd_snap_r <= 16'h0000;
         wr_data_r <= 16'h0000;
         wr_stb_r <= 1'b0;
         rd_done_r <= 1'b0;
      end else begin
         wr_stb_r <= 1'b0;
         rd_done_r <= 1'b0;
         if (start_det) begin
            st_r <= S_RX;
            idx_r <= 2'd0;
            bit_cnt_r <= 4'h0;
            sda_low_r <= 1'b0;
         end else if (stop_det) begin
            st_r <= S_IDLE;
            sda_low_r <= 1'b0;
         end else begin
            case (st_r)
               S_RX: begin
                  if (scl_rise) begin
                     shift_r <= {shift_r[6:0], pin[IX_SDA]};
                     bit_cnt_r <= bit_cnt_r + 4'h1;
                  end else if (byte_done) begin
                     bit_cnt_r <= 4'h0;
                     st_r <= rx_ack ? S_ACKO : S_SKIP;
                     sda_low_r <= rx_ack;
                     case (idx_r)
                        2'd0: begin
                           nxt_st_r <= is_read ? S_TX : S_RX;
                           idx_r <= is_read ? 2'd0 : 2'd1;
                           tx_sh_r <= rd_word[7:0];
                           tx_hi_r <= rd_word[15:8];
                           rd_snap_r <= rd_word;
                           hi_sent_r <= 1'b0;
                        end
                        2'd1: begin
                           cmd_r <= shift_r;
                           idx_r <= 2'd2;
                           nxt_st_r <= S_RX;
                        end
                        2'd2: begin
                           wlo_r <= shift_r;
                           idx_r <= 2'd3;
                           nxt_st_r <= S_RX;
                        end
                        default: begin
                           wr_stb_r <= 1'b1;
                           wr_data_r <= {shift_r, wlo_r};
                           nxt_st_r <= S_SKIP;
                        end
                     endcase
                  end
               end
               S_ACKO: begin
                  if (scl_fall) begin
                     st_r <= nxt_st_r;
                     sda_low_r <= (nxt_st_r == S_TX) && !tx_sh_r[7];
                  end
               end
               S_TX: begin
                  if (scl_rise) begin
                     bit_cnt_r <= bit_cnt_r + 4'h1;
                  end else if (byte_done) begin
                     bit_cnt_r <= 4'h0;
                     st_r <= S_ACKI;
                     sda_low_r <= 1'b0;
                  end else if (scl_fall) begin
                     tx_sh_r <= {tx_sh_r[6:0], 1'b0};
                     sda_low_r <= !tx_sh_r[6];
                  end
               end
               S_ACKI: begin
                  if (scl_rise) begin
                     if (hi_sent_r) begin
                        rd_done_r <= 1'b1;
                        st_r <= S_SKIP;
                     end else if (!pin[IX_SDA]) begin
                        tx_sh_r <= tx_hi_r;
                        hi_sent_r <= 1'b1;
                        nxt_st_r <= S_TX;
                        st_r <= S_ACKO;
                     end else begin
                        st_r <= S_SKIP;
                     end
                  end
               end
               default: begin
                  sda_low_r <= 1'b0;
               end
            endcase
         end
      end
   end

   // Only flags that went out in the snapshot are cleared, and a new
   // event in the clear cycle wins.
   wire st_rd_clr = rd_done_r && (cmd_r == CMD_STATUS);
   wire trg_rd_clr = rd_done_r && (cmd_r == CMD_PROCESSOR_HOT_SIGNAL);
   wire [FLT_N-1:0] flt_seen = {rd_snap_r[7:5], rd_snap_r[2:0]};
   wire [FLT_N-1:0] flt_ev = pin[IX_FLT +: FLT_N];
   assign flt_nxt = (flt_r & ~(flt_seen & {FLT_N{st_rd_clr}}))
      | flt_ev;
   assign trg_nxt = (trg_r & ~(rd_snap_r[TRG_N-1:0] & {TRG_N{trg_rd_clr}}))
      | pin[IX_TRG +: TRG_N];

   // The latch survives removal of the condition until cleared.
   wire sovp_host_clr = wr_stb_r && (cmd_r == CMD_STATUS)
      && !wr_data_r[ST_SOVP_BIT];
   assign sovp_nxt = pin[IX_SOVP]
      | (sovp_r & ~sovp_host_clr & pin[IX_ADP]);

   // Clears take priority over a host write in the same cycle.
   wire cc_clr = (adp_fall && !pin[IX_ACOV]) || batp_fall;
   wire cc_wr = wr_stb_r && (cmd_r == CMD_CHG_CUR)
      && (wr_data_r[WORD_W-1:CC_RSV_LSB] == 3'b000);
   assign cc_nxt = cc_clr ? CC_RST :
      cc_wr ? wr_data_r[CC_LSB +: CC_W] : cc_r;

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         flt_r <= FLT_RST;
         trg_r <= TRG_RST;
         sovp_r <= SOVP_RST;
         conv_en_r <= CONV_EN_RST;
         cc_r <= CC_RST;
      end else begin
         flt_r <= flt_nxt;
         trg_r <= trg_nxt;
         sovp_r <= sovp_nxt;
         conv_en_r <= !sovp_nxt;
         cc_r <= cc_nxt;
      end
   end

   assign smbus_sda_o = 1'b0;
   assign smbus_sda_oe = sda_low_r;
   assign converter_enable = conv_en_r;
   assign charge_current_code = cc_r;

   conv_off_a: assert property (pin[IX_SOVP] |=> sovp_r && !conv_en_r)
      else $error("Converter enabled while overvoltage latch set.");
   ovp_hold_a: assert property (sovp_r && pin[IX_ADP] && !sovp_host_clr
      |=> sovp_r)
      else $error("Overvoltage latch dropped without a clear.");
   ovp_unplug_a: assert property (sovp_r && !pin[IX_ADP] && !pin[IX_SOVP]
      |=> !sovp_r && conv_en_r)
      else $error("Unplug did not clear overvoltage latch.");
   flt_hold_a: assert property (!st_rd_clr
      |=> (flt_r & $past(flt_r)) == $past(flt_r))
      else $error("Fault flag cleared without a host read.");
   set_wins_a: assert property (st_rd_clr && pin[IX_ACOV]
      |=> flt_r[5])
      else $error("Fault event lost in clear cycle.");
   rd_clear_a: assert property (st_rd_clr && rd_snap_r[7] && !pin[IX_ACOV]
      |=> !flt_r[5])
      else $error("Seen fault flag not cleared after read.");
   cc_adapter_a: assert property (adp_fall && !pin[IX_ACOV]
      |=> cc_r == CC_RST)
      else $error("Adapter drop kept charge current.");
   cc_battery_a: assert property (batp_fall |=> cc_r == CC_RST)
      else $error("Battery removal kept charge current.");
   cc_invalid_a: assert property (wr_stb_r && (cmd_r == CMD_CHG_CUR)
      && (|wr_data_r[WORD_W-1:CC_RSV_LSB]) && !cc_clr
      |=> $stable(cc_r))
      else $error("Write with reserved bits changed current.");
   cc_keep_a: assert property (!cc_clr && !cc_wr |=> $stable(cc_r))
      else $error("Charge current changed without cause.");
   trg_latch_a: assert property (pin[IX_TRG] |=> trg_r[0]
      ##1 (trg_r[0] || $past(trg_rd_clr)))
      else $error("Trigger flag did not latch.");
endmodule // cscr_regs

// ---- dv/cscr_host_model.sv ----
// SMBus host model that clocks word reads and writes into the registers.
`timescale 1ns/1ps
module cscr_host_model #(
   parameter logic [6:0] ADDR = 7'h5A
) (
   input wire logic clk_sys,
   input wire logic sda,
   output logic scl,
   output logic sda_low
);
   // Half period of the bus clock, above the eight cycles the device needs.
   localparam int H = 10;
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(negedge clk_sys);
   endtask
   task automatic bit_io(input logic b, output logic r);
      sda_low = !b;
      tick(H);
      scl = 1'b1;
      tick(H);
      r = sda;
      scl = 1'b0;
      tick(2);
   endtask
   task automatic start(input logic rep);
      if (rep) begin
         sda_low = 1'b0;
         tick(H);
         scl = 1'b1;
         tick(H);
      end
      sda_low = 1'b1;
      tick(H);
      scl = 1'b0;
      tick(2);
   endtask
   task automatic stop();
      sda_low = 1'b1;
      tick(H);
      scl = 1'b1;
      tick(H);
      sda_low = 1'b0;
      tick(H);
   endtask
   task automatic put(input logic [7:0] b, output logic ok);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(b[i], r);
      bit_io(1'b1, r);
      ok = !r;
   endtask
   task automatic get(input logic ack, output logic [7:0] b);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
      bit_io(!ack, r);
   endtask
   task automatic wr(input logic [7:0] cmd, input logic [15:0] d,
                     output logic ok);
      logic a0, a1, a2, a3;
      start(1'b0);
      put({ADDR, 1'b0}, a0);
      put(cmd, a1);
      put(d[7:0], a2);
      put(d[15:8], a3);
      stop();
      ok = a0 & a1 & a2 & a3;
   endtask
   task automatic rd(input logic [7:0] cmd, output logic [15:0] d,
                     output logic ok);
      logic a0, a1, a2;
      logic [7:0] lo, hi;
      start(1'b0);
      put({ADDR, 1'b0}, a0);
      put(cmd, a1);
      start(1'b1);
      put({ADDR, 1'b1}, a2);
      get(1'b1, lo);
      // The whole word is always read so that latched flags are released.
      get(1'b0, hi);
      stop();
      d = {hi, lo};
      ok = a0 & a1 & a2;
   endtask
   // Reads the low byte only and refuses the high byte.
   task automatic rd_lo(input logic [7:0] cmd, output logic [7:0] lo);
      logic a;
      start(1'b0);
      put({ADDR, 1'b0}, a);
      put(cmd, a);
      start(1'b1);
      put({ADDR, 1'b1}, a);
      get(1'b0, lo);
      stop();
   endtask
endmodule // cscr_host_model

// ---- dv/tb_cscr_regs.sv ----
// Self-checking bench for the charger status and current registers.
`timescale 1ns/1ps
module tb_cscr_regs;
   import cscr_pkg::*;
   // Rows hold the live status inputs beside the status word they give.
   localparam logic [22:0] ROWS [9] = '{
      {7'h40, 16'h8000}, {7'h20, 16'h4000}, {7'h10, 16'h1000},
      {7'h08, 16'h0800}, {7'h04, 16'h0400}, {7'h02, 16'h0200},
      {7'h01, 16'h0100}, {7'h7F, 16'hDF00}, {7'h00, 16'h0000}};
   logic clk_sys = 1'b0;
   logic rstn = 1'b0;
   logic bat = 1'b1;
   logic ovd = 1'b0;
   logic [6:0] live = 7'h00;
   logic [5:0] flt = 6'h00;
   logic [6:0] trg = 7'h00;
   logic scl, host_low, sda_o, sda_oe, conv_en, ok;
   logic [CC_W-1:0] code;
   logic [15:0] rv;
   int n_errors = 0;
   int checked = 0;
   // The bus line has a pull-up, so it is low only while someone pulls it.
   wire logic sda = !(host_low || sda_oe);
   always #12.5 clk_sys = !clk_sys;
   cscr_regs u_dut (.clk_sys(clk_sys), .rstn(rstn), .smbus_scl(scl),
      .smbus_sda_i(sda), .smbus_sda_o(sda_o), .smbus_sda_oe(sda_oe),
      .adapter_good_pin(live[6]), .current_optimizer_done(live[5]),
      .input_voltage_regulating(live[4]),
      .input_current_regulating(live[3]), .fast_charge_active(live[2]),
      .precharge_active(live[1]), .reverse_boost_active(live[0]),
      .input_overvoltage_fault(flt[5]), .battery_overcurrent_fault(flt[4]),
      .input_overcurrent_fault(flt[3]), .latchoff_fault(flt[2]),
      .reverse_overvoltage_fault(flt[1]),
      .reverse_overcurrent_fault(flt[0]),
      .system_overvoltage_detect(ovd),
      .cell_count_battery_present_pin(bat),
      .processor_hot_trigger(trg), .converter_enable(conv_en),
      .charge_current_code(code));
   cscr_host_model u_host (.clk_sys(clk_sys), .sda(sda), .scl(scl),
      .sda_low(host_low));
   task automatic tick(input int n);
      repeat (n) @(negedge clk_sys);
   endtask
   task automatic check(input string nm, input logic [15:0] seen,
                        input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] cmd, input logic [15:0] d);
      u_host.wr(cmd, d, ok);
      check("write_ack", {15'h0000, ok}, 16'h0001);
   endtask
   task automatic rdchk(input logic [7:0] cmd, input logic [15:0] exp,
                        input string nm);
      u_host.rd(cmd, rv, ok);
      check(nm, rv, exp);
   endtask
   task automatic results();
      $display("checked %0d n_errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial begin
      tick(10);
      rstn = 1'b1;
      tick(8);
      rdchk(CMD_CHG_CUR, 16'h0000, "cc_reset");
      rdchk(CMD_PROCESSOR_HOT_SIGNAL, 16'h0000, "trig_reset");
      check("conv_reset", {15'h0000, conv_en}, 16'h0001);
      check("sda_o", {15'h0000, sda_o}, 16'h0000);
      for (int i = 0; i < 9; i++) begin
         live = ROWS[i][22:16];
         tick(8);
         rdchk(CMD_STATUS, ROWS[i][15:0], "live");
      end
      wr(CMD_CHG_CUR, 16'h0FC0);
      check("code", {9'h000, code}, 16'h003F);
      wr(CMD_CHG_CUR, 16'h2040);
      rdchk(CMD_CHG_CUR, 16'h0FC0, "cc_rsv");
      wr(CMD_CHG_CUR, 16'h1FFF);
      rdchk(CMD_CHG_CUR, 16'h1FC0, "cc_max");
      flt = 6'h3F;
      tick(8);
      flt = 6'h00;
      tick(8);
      check("code_flt", {9'h000, code}, 16'h007F);
      u_host.rd_lo(CMD_STATUS, rv[7:0]);
      check("faults_lo", {8'h00, rv[7:0]}, 16'h00E7);
      rdchk(CMD_STATUS, 16'h00E7, "faults");
      rdchk(CMD_STATUS, 16'h0000, "faults_clr");
      live = 7'h40;
      ovd = 1'b1;
      tick(8);
      check("conv_ov", {15'h0000, conv_en}, 16'h0000);
      rdchk(CMD_STATUS, 16'h8010, "ov_live");
      ovd = 1'b0;
      tick(8);
      rdchk(CMD_STATUS, 16'h8010, "ov_held");
      check("code_ov", {9'h000, code}, 16'h007F);
      // Writing zero to the latch bit releases the converter.
      wr(CMD_STATUS, 16'h0000);
      check("conv_wr", {15'h0000, conv_en}, 16'h0001);
      rdchk(CMD_STATUS, 16'h8000, "ov_clr");
      ovd = 1'b1;
      tick(8);
      ovd = 1'b0;
      flt = 6'h20;
      tick(8);
      live = 7'h00;
      tick(8);
      flt = 6'h00;
      tick(8);
      check("conv_unplug", {15'h0000, conv_en}, 16'h0001);
      check("code_acov", {9'h000, code}, 16'h007F);
      rdchk(CMD_STATUS, 16'h0080, "acov");
      live = 7'h40;
      tick(8);
      live = 7'h00;
      tick(8);
      check("code_drop", {9'h000, code}, 16'h0000);
      live = 7'h40;
      tick(8);
      wr(CMD_CHG_CUR, 16'h0FC0);
      bat = 1'b0;
      tick(8);
      check("code_bat", {9'h000, code}, 16'h0000);
      bat = 1'b1;
      trg = 7'h7F;
      tick(8);
      trg = 7'h00;
      tick(8);
      rdchk(CMD_PROCESSOR_HOT_SIGNAL, 16'h007F, "trig");
      rdchk(CMD_PROCESSOR_HOT_SIGNAL, 16'h0000, "trig_clr");
      wr(CMD_PROCESSOR_HOT_SIGNAL, 16'h007F);
      rdchk(CMD_PROCESSOR_HOT_SIGNAL, 16'h0000, "trig_wr");
      rdchk(8'h30, 16'h0000, "unmapped");
      // A reset in mid-run must drop the setting and every latched flag.
      wr(CMD_CHG_CUR, 16'h0FC0);
      flt = 6'h3F;
      tick(8);
      flt = 6'h00;
      rstn = 1'b0;
      tick(2);
      check("code_rst", {9'h000, code}, 16'h0000);
      check("conv_rst", {15'h0000, conv_en}, 16'h0001);
      rstn = 1'b1;
      tick(8);
      rdchk(CMD_STATUS, 16'h8000, "st_rst");
      rdchk(CMD_CHG_CUR, 16'h0000, "cc_rst");
      results();
   end
   initial begin
      repeat (80000) @(posedge clk_sys);
      n_errors++;
      results();
   end
endmodule // tb_cscr_regs
